// *** hdl/pmx_top.sv ***
// Pin reset state and function select for a four-channel amplifier controller.
// Assumes an APB master on CORE_CLK and pad cells resolving o/oe/i triples.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pmx_params.svh"
module pmx_top
  import pmx_pkg::*;
#(
  parameter int GP_W  = 8,
  parameter int XGP_W = 14
) (
  input  wire logic                CORE_CLK,
  input  wire logic                ARST_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                TOPOLOGY_SELECT_IN,
  input  wire logic [PMX_NCH-1:0]  PWM_HI_REQ,
  input  wire logic [PMX_NCH-1:0]  PWM_LO_REQ,
  output logic      [PMX_NCH-1:0]  HIGH_SIDE_DRIVE,
  output logic      [PMX_NCH-1:0]  LOW_SIDE_DRIVE,
  input  wire logic                PWM_SYNC_LINE_I,
  output logic                     PWM_SYNC_LINE_O,
  output logic                     PWM_SYNC_LINE_OE,
  input  wire logic                PWM_SYNC_TX,
  output logic                     PWM_SYNC_RX,
  input  wire logic [3:0]          BOOT_SELECT_IN,
  output logic      [3:0]          BOOT_SELECT,
  output logic                     BOOT_VALID,
  input  wire logic                POR_DETECT,
  input  wire logic                BROWNOUT_3V3,
  input  wire logic                BROWNOUT_1V8,
  output logic                     RESET_INDICATOR_OUT_LOW,
  input  wire logic                TEST_PORT_RESET_LOW,
  input  wire logic                TEST_MODE_IN,
  input  wire logic                CRYSTAL_IN,
  output logic                     OSC_BUFFER_OUT,
  input  wire logic [GP_W-1:0]     GP_PIN_I,
  output logic      [GP_W-1:0]     GP_PIN_O,
  output logic      [GP_W-1:0]     GP_PIN_OE,
  input  wire logic [XGP_W-1:0]    EXTENDED_GP_PINS_I,
  output logic      [XGP_W-1:0]    EXTENDED_GP_PINS_O,
  output logic      [XGP_W-1:0]    EXTENDED_GP_PINS_OE,
  input  wire logic [PMX_MF_W-1:0] MF_PIN_I,
  output logic      [PMX_MF_W-1:0] MF_PIN_O,
  output logic      [PMX_MF_W-1:0] MF_PIN_OE,
  input  wire logic [PMX_MF_W-1:0] MF_FUNC_O,
  input  wire logic [PMX_MF_W-1:0] MF_FUNC_OE,
  output logic      [PMX_MF_W-1:0] MF_FUNC_I
);
  localparam int PIO_W = GP_W + XGP_W;
  localparam logic [PMX_MF_W-1:0] MF_OE_RST = `PMX_MF_DIR_RST;
  localparam logic [PMX_MF_W-1:0] MF_O_RST  = `PMX_MF_OUT_RST;

  if (GP_W < 1 || XGP_W < 1 || PIO_W > 32) begin : g_chk
    $error("pmx_top: general pin widths must be 1..32 in total");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Strap syncs carry no reset so they follow the pins while reset is held
  logic                topo_s1_ff;
  logic                topo_s2_ff;
  logic [3:0]          boot_s1_ff;
  logic [3:0]          boot_s2_ff;
  logic [PMX_MF_W-1:0] mf_s1_ff;
  logic [PMX_MF_W-1:0] mf_s2_ff;
  logic [PIO_W-1:0]    pio_s1_ff;
  logic [PIO_W-1:0]    pio_s2_ff;
  logic [2:0]          misc_s1_ff;
  logic [2:0]          misc_s2_ff;

  always_ff @(posedge CORE_CLK) begin
    topo_s1_ff <= TOPOLOGY_SELECT_IN;
    topo_s2_ff <= topo_s1_ff;
    boot_s1_ff <= BOOT_SELECT_IN;
    boot_s2_ff <= boot_s1_ff;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mf_s1_ff   <= '0;
      mf_s2_ff   <= '0;
      pio_s1_ff  <= '0;
      pio_s2_ff  <= '0;
      misc_s1_ff <= 3'h0;
      misc_s2_ff <= 3'h0;
    end else begin
      mf_s1_ff   <= MF_PIN_I;
      mf_s2_ff   <= mf_s1_ff;
      pio_s1_ff  <= {EXTENDED_GP_PINS_I, GP_PIN_I};
      pio_s2_ff  <= pio_s1_ff;
      misc_s1_ff <= {TEST_MODE_IN, TEST_PORT_RESET_LOW, PWM_SYNC_LINE_I};
      misc_s2_ff <= misc_s1_ff;
    end
  end

  assign MF_FUNC_I   = mf_s2_ff;
  assign PWM_SYNC_RX = misc_s2_ff[0];

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [1:0]       ctrl_ff;
  pmx_mf_cfg_t      mf_cfg_ff;
  logic [PIO_W-1:0] pio_dir_ff;
  logic [PIO_W-1:0] pio_out_ff;
  logic [31:0]      prdata_ff;
  logic             pslverr_ff;
  logic [31:0]      nxt_prdata;
  logic             nxt_pslverr;
  logic [3:0]       boot_ff;
  logic             rsto_s1_ff;
  logic             rsto_s2_ff;
  pmx_boot_st_t     boot_st_ff;
  logic             wr_en;

  // Zero wait states: read data is latched in the setup cycle
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_ff;
  assign PSLVERR = pslverr_ff;

  always_comb begin
    nxt_prdata  = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (PADDR == `PMX_OFS_CTRL) begin
      nxt_prdata[1:0] = ctrl_ff;
    end else if (PADDR == `PMX_OFS_STATUS) begin
      nxt_prdata[3:0]              = boot_ff;
      nxt_prdata[`PMX_ST_TOPO]     = topo_s2_ff;
      nxt_prdata[`PMX_ST_BOOT_VLD] = (boot_st_ff == PMX_BOOT_DONE);
      nxt_prdata[`PMX_ST_TRST_LOW] = misc_s2_ff[1];
      nxt_prdata[`PMX_ST_TEST_MODE] = misc_s2_ff[2];
      nxt_prdata[`PMX_ST_RST_IND]  = rsto_s2_ff;
    end else if (PADDR == `PMX_OFS_MF_SEL) begin
      nxt_prdata[PMX_MF_W-1:0] = mf_cfg_ff.sel;
    end else if (PADDR == `PMX_OFS_MF_DIR) begin
      nxt_prdata[PMX_MF_W-1:0] = mf_cfg_ff.dir;
    end else if (PADDR == `PMX_OFS_MF_OUT) begin
      nxt_prdata[PMX_MF_W-1:0] = mf_cfg_ff.out;
    end else if (PADDR == `PMX_OFS_MF_IN) begin
      nxt_prdata[PMX_MF_W-1:0] = mf_s2_ff;
    end else if (PADDR == `PMX_OFS_GP_DIR) begin
      nxt_prdata[PIO_W-1:0] = pio_dir_ff;
    end else if (PADDR == `PMX_OFS_GP_OUT) begin
      nxt_prdata[PIO_W-1:0] = pio_out_ff;
    end else if (PADDR == `PMX_OFS_GP_IN) begin
      nxt_prdata[PIO_W-1:0] = pio_s2_ff;
    end else begin
      nxt_pslverr = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      prdata_ff  <= PWRITE ? 32'h00000000 : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Read-only offsets ignore writes; only unmapped offsets raise an error
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff       <= `PMX_CTRL_RST;
      mf_cfg_ff.sel <= `PMX_MF_SEL_RST;
      mf_cfg_ff.dir <= `PMX_MF_DIR_RST;
      mf_cfg_ff.out <= `PMX_MF_OUT_RST;
      pio_dir_ff    <= '0;
      pio_out_ff    <= '0;
    end else if (wr_en) begin
      if (PADDR == `PMX_OFS_CTRL) begin
        ctrl_ff <= PWDATA[1:0];
      end else if (PADDR == `PMX_OFS_MF_SEL) begin
        mf_cfg_ff.sel <= PWDATA[PMX_MF_W-1:0];
      end else if (PADDR == `PMX_OFS_MF_DIR) begin
        mf_cfg_ff.dir <= PWDATA[PMX_MF_W-1:0];
      end else if (PADDR == `PMX_OFS_MF_OUT) begin
        mf_cfg_ff.out <= PWDATA[PMX_MF_W-1:0];
      end else if (PADDR == `PMX_OFS_GP_DIR) begin
        pio_dir_ff <= PWDATA[PIO_W-1:0];
      end else if (PADDR == `PMX_OFS_GP_OUT) begin
        pio_out_ff <= PWDATA[PIO_W-1:0];
      end
    end
  end

  assign GP_PIN_OE           = pio_dir_ff[GP_W-1:0];
  assign GP_PIN_O            = pio_out_ff[GP_W-1:0];
  assign EXTENDED_GP_PINS_OE = pio_dir_ff[PIO_W-1:GP_W];
  assign EXTENDED_GP_PINS_O  = pio_out_ff[PIO_W-1:GP_W];

  // ----------------------------------------------------------------
  // Multifunction pad mux
  // ----------------------------------------------------------------
  logic [PMX_MF_W-1:0] mf_o_ff;
  logic [PMX_MF_W-1:0] mf_oe_ff;

  for (genvar k = 0; k < PMX_MF_W; k++) begin : g_mf
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        mf_o_ff[k]  <= MF_O_RST[k];
        mf_oe_ff[k] <= MF_OE_RST[k];
      end else if (mf_cfg_ff.sel[k]) begin
        mf_o_ff[k]  <= mf_cfg_ff.out[k];
        mf_oe_ff[k] <= mf_cfg_ff.dir[k];
      end else begin
        mf_o_ff[k]  <= MF_FUNC_O[k];
        mf_oe_ff[k] <= MF_FUNC_OE[k];
      end
    end
  end

  // Protection and temperature inputs pass the same mux
  assign MF_PIN_O  = mf_o_ff;
  assign MF_PIN_OE = mf_oe_ff;

  // ----------------------------------------------------------------
  // PWM drive and protection
  // ----------------------------------------------------------------
  logic [PMX_NCH-1:0] hs_on_ff;
  logic [PMX_NCH-1:0] ls_on_ff;
  logic [PMX_NCH-1:0] fault;

  for (genvar c = 0; c < PMX_NCH; c++) begin : g_ch
    // Faults count only while the pin serves its protection function
    assign fault[c] = (!mf_cfg_ff.sel[`PMX_MF_OC0 + c] && mf_s2_ff[`PMX_MF_OC0 + c])
                   || (!mf_cfg_ff.sel[`PMX_MF_ST0 + c] && mf_s2_ff[`PMX_MF_ST0 + c]);
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        hs_on_ff[c] <= 1'b0;
        ls_on_ff[c] <= 1'b0;
      end else begin
        hs_on_ff[c] <= PWM_HI_REQ[c] && !fault[c];
        ls_on_ff[c] <= PWM_LO_REQ[c] && !fault[c];
      end
    end
  end

  // High strap means active-low high-side drive, so its idle level equals the strap
  assign HIGH_SIDE_DRIVE = hs_on_ff ^ {PMX_NCH{topo_s2_ff}};
  assign LOW_SIDE_DRIVE  = ls_on_ff;

  // ----------------------------------------------------------------
  // PWM sync line
  // ----------------------------------------------------------------
  logic sync_o_ff;
  logic sync_oe_ff;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync_o_ff  <= 1'b0;
      sync_oe_ff <= 1'b0;
    end else begin
      sync_o_ff  <= PWM_SYNC_TX;
      sync_oe_ff <= ctrl_ff[`PMX_CTRL_MASTER];
    end
  end

  assign PWM_SYNC_LINE_O  = sync_o_ff;
  assign PWM_SYNC_LINE_OE = sync_oe_ff;

  // ----------------------------------------------------------------
  // Boot select capture
  // ----------------------------------------------------------------
  // ARST_N loads reset values into every process above except the strap synchronisers
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      boot_st_ff <= PMX_BOOT_WAIT;
      boot_ff    <= 4'h0;
    end else begin
      case (boot_st_ff)
        PMX_BOOT_WAIT: begin
          boot_ff    <= boot_s2_ff;
          boot_st_ff <= PMX_BOOT_DONE;
        end
        default: begin
          boot_st_ff <= PMX_BOOT_DONE;
        end
      endcase
    end
  end

  assign BOOT_SELECT = boot_ff;
  assign BOOT_VALID  = (boot_st_ff == PMX_BOOT_DONE);

  // ----------------------------------------------------------------
  // Reset indicator and oscillator buffer
  // ----------------------------------------------------------------
  // Detectors assert asynchronously, release is stretched two clocks
  logic det_n;
  assign det_n = !(POR_DETECT || BROWNOUT_3V3 || BROWNOUT_1V8);

  always_ff @(posedge CORE_CLK or negedge det_n) begin
    if (!det_n) begin
      rsto_s1_ff <= 1'b0;
      rsto_s2_ff <= 1'b0;
    end else begin
      rsto_s1_ff <= 1'b1;
      rsto_s2_ff <= rsto_s1_ff;
    end
  end

  assign RESET_INDICATOR_OUT_LOW = rsto_s2_ff;
  // Analog-style gate: a program stop may clip the last crystal pulse
  assign OSC_BUFFER_OUT = CRYSTAL_IN && !ctrl_ff[`PMX_CTRL_OSC_OFF];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  polarity_idle_a: assert property (!PWM_HI_REQ[0] ##1 $stable(topo_s2_ff) |-> HIGH_SIDE_DRIVE[0] == topo_s2_ff)
    else $error("high side not at idle level");
  sync_float_a: assert property (boot_st_ff == PMX_BOOT_WAIT |-> !PWM_SYNC_LINE_OE)
    else $error("sync line driven at reset");
  sync_master_a: assert property (ctrl_ff[`PMX_CTRL_MASTER] [*2] |-> PWM_SYNC_LINE_OE)
    else $error("master not driving sync line");
  xgp_input_a: assert property (boot_st_ff == PMX_BOOT_WAIT |-> EXTENDED_GP_PINS_OE == '0)
    else $error("extended pin driving after reset");
  gp_input_a: assert property (boot_st_ff == PMX_BOOT_WAIT |-> GP_PIN_OE == '0)
    else $error("general pin driving after reset");
  boot_capture_a: assert property (boot_st_ff == PMX_BOOT_WAIT |=> BOOT_VALID && BOOT_SELECT == $past(boot_s2_ff))
    else $error("boot select not captured");
  boot_hold_a: assert property (BOOT_VALID |=> BOOT_VALID && $stable(BOOT_SELECT))
    else $error("boot select changed");
  reset_ind_a: assert property (POR_DETECT || BROWNOUT_3V3 || BROWNOUT_1V8 |-> !RESET_INDICATOR_OUT_LOW)
    else $error("reset indicator not low");
  osc_off_a: assert property (ctrl_ff[`PMX_CTRL_OSC_OFF] |-> !OSC_BUFFER_OUT)
    else $error("oscillator buffer not gated");
  pump_low_a: assert property (boot_st_ff == PMX_BOOT_WAIT |-> MF_PIN_OE[`PMX_MF_PUMP_HI] && !MF_PIN_O[`PMX_MF_PUMP_HI])
    else $error("pump not driving low at reset");
  gpio_mode_a: assert property (mf_cfg_ff.sel[`PMX_MF_RXD] && mf_cfg_ff.dir[`PMX_MF_RXD] |=> MF_PIN_OE[`PMX_MF_RXD])
    else $error("receive pin not driving in gpio mode");
  oc_gate_a: assert property (fault[0] |=> !LOW_SIDE_DRIVE[0] ##0 HIGH_SIDE_DRIVE[0] == topo_s2_ff)
    else $error("channel not forced off on fault");
  st_gate_a: assert property (!mf_cfg_ff.sel[`PMX_MF_ST0 + 1] && mf_s2_ff[`PMX_MF_ST0 + 1] |=> !LOW_SIDE_DRIVE[1])
    else $error("shoot-through did not gate channel");

  boot_seen_c: cover property (boot_st_ff == PMX_BOOT_WAIT ##1 BOOT_VALID);
  master_on_c: cover property (PWM_SYNC_LINE_OE ##1 PWM_SYNC_LINE_O);
  fault_hit_c: cover property (PWM_LO_REQ[0] && fault[0]);
  pump_gpio_c: cover property (mf_cfg_ff.sel[`PMX_MF_PUMP_LO] && MF_PIN_O[`PMX_MF_PUMP_LO]);
endmodule
`default_nettype wire

// *** hdl/pmx_params.svh ***
// Offsets, field positions and reset values of the pin control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMX_OFS_CTRL     8'h00
`define PMX_OFS_STATUS   8'h04
`define PMX_OFS_MF_SEL   8'h08
`define PMX_OFS_MF_DIR   8'h0C
`define PMX_OFS_MF_OUT   8'h10
`define PMX_OFS_MF_IN    8'h14
`define PMX_OFS_GP_DIR   8'h18
`define PMX_OFS_GP_OUT   8'h1C
`define PMX_OFS_GP_IN    8'h20
// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define PMX_CTRL_OSC_OFF 0
`define PMX_CTRL_MASTER  1
`define PMX_ST_TOPO      4
`define PMX_ST_BOOT_VLD  5
`define PMX_ST_TRST_LOW  6
`define PMX_ST_TEST_MODE 7
`define PMX_ST_RST_IND   8
// ----------------------------------------------------------------
// Multifunction pin indices
// ----------------------------------------------------------------
`define PMX_MF_RXD       0
`define PMX_MF_TXD       1
`define PMX_MF_AUD0      2
`define PMX_MF_AUD1      8
`define PMX_MF_TIMER     14
`define PMX_MF_PUMP_HI   16
`define PMX_MF_PUMP_LO   17
`define PMX_MF_PS_SYNC   18
`define PMX_MF_TEMP      19
`define PMX_MF_OC0       20
`define PMX_MF_ST0       24
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMX_CTRL_RST     2'h0
`define PMX_MF_SEL_RST   28'h0000000
`define PMX_MF_DIR_RST   28'h0030000
`define PMX_MF_OUT_RST   28'h0000000
`endif

// *** hdl/pmx_pkg.sv ***
// Types shared by the pin control block.
// Assumes the params header is on the include path.
package pmx_pkg;
  `include "pmx_params.svh"
  localparam int PMX_MF_W = 28;
  localparam int PMX_NCH  = 4;

  typedef struct packed {
    logic [PMX_MF_W-1:0] sel;
    logic [PMX_MF_W-1:0] dir;
    logic [PMX_MF_W-1:0] out;
  } pmx_mf_cfg_t;

  typedef enum logic [0:0] {
    PMX_BOOT_WAIT = 1'b0,
    PMX_BOOT_DONE = 1'b1
  } pmx_boot_st_t;
endpackage

// *** test/pmx_board.sv ***
// Board model: test pins, crystal and multifunction/sync wires.
// Assumes the bench supplies the board's own pin levels and system reset.
`timescale 1ns/100ps
`default_nettype none
module pmx_board (
  input  wire logic        sys_rst_n,
  input  wire logic [27:0] mf_o,
  input  wire logic [27:0] mf_oe,
  input  wire logic [27:0] mf_ext,
  input  wire logic        sync_o,
  input  wire logic        sync_oe,
  input  wire logic        sync_ext,
  output logic      [27:0] mf_i,
  output logic             sync_i,
  output logic             trst_n,
  output logic             test_mode,
  output logic             crystal
);
  // Crystal edges land on multiples of 30 ns, never on a bench sample instant
  initial begin
    crystal = 1'b0;
    forever #30 crystal = ~crystal;
  end
  // A pad driven by the device wins; otherwise board parts set the level
  assign mf_i      = (mf_oe & mf_o) | (~mf_oe & mf_ext);
  assign sync_i    = sync_oe ? sync_o : sync_ext;
  assign trst_n    = sys_rst_n;
  assign test_mode = 1'b0;
endmodule
`default_nettype wire

// *** test/tb_pin_reset_state_and_function_select.sv ***
// Bench for the pin control block: APB driver, register model, pad checks.
// Assumes pmx_pkg, pmx_top and the board model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "pmx_params.svh"
module tb_pin_reset_state_and_function_select;
  import pmx_pkg::*;
  localparam logic [31:0] PUMPS = (32'h1 << `PMX_MF_PUMP_HI) | (32'h1 << `PMX_MF_PUMP_LO);
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, topo = 1'b1;
  logic        sync_tx = 1'b0, sync_ext = 1'b0, por = 1'b0, bo33 = 1'b0, bo18 = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  hi_req = 4'h0, lo_req = 4'h0, boot_in = 4'hA;
  logic [21:0] gp_ext = 22'h0;
  logic [27:0] mf_ext = 28'h0, f_o = 28'h0, f_oe = 28'h0;
  logic        pready, pslverr, sync_i, sync_o, sync_oe, sync_rx, boot_vld, rst_ind_n, trst_n, test_mode;
  logic        xtal, osc_out, err;
  logic [7:0]  gp_o, gp_oe;
  logic [13:0] xg_o, xg_oe;
  logic [21:0] gp_i;
  logic [31:0] prdata, rd, mdl [logic [7:0]];
  logic [3:0]  hs, ls, boot, flt;
  logic [27:0] mf_o, mf_oe, mf_i, f_i, s, eo, eoe;
  logic [7:0]  ofs [6] = '{`PMX_OFS_CTRL, `PMX_OFS_MF_SEL, `PMX_OFS_MF_DIR, `PMX_OFS_MF_OUT,
                           `PMX_OFS_GP_DIR, `PMX_OFS_GP_OUT};
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          seed = 91;

  pmx_top dut (
    .CORE_CLK(clk), .ARST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TOPOLOGY_SELECT_IN(topo),
    .PWM_HI_REQ(hi_req), .PWM_LO_REQ(lo_req), .HIGH_SIDE_DRIVE(hs), .LOW_SIDE_DRIVE(ls),
    .PWM_SYNC_LINE_I(sync_i), .PWM_SYNC_LINE_O(sync_o), .PWM_SYNC_LINE_OE(sync_oe), .PWM_SYNC_TX(sync_tx),
    .PWM_SYNC_RX(sync_rx), .BOOT_SELECT_IN(boot_in), .BOOT_SELECT(boot), .BOOT_VALID(boot_vld),
    .POR_DETECT(por), .BROWNOUT_3V3(bo33), .BROWNOUT_1V8(bo18), .RESET_INDICATOR_OUT_LOW(rst_ind_n),
    .TEST_PORT_RESET_LOW(trst_n), .TEST_MODE_IN(test_mode), .CRYSTAL_IN(xtal), .OSC_BUFFER_OUT(osc_out),
    .GP_PIN_I(gp_i[7:0]), .GP_PIN_O(gp_o), .GP_PIN_OE(gp_oe), .EXTENDED_GP_PINS_I(gp_i[21:8]),
    .EXTENDED_GP_PINS_O(xg_o), .EXTENDED_GP_PINS_OE(xg_oe), .MF_PIN_I(mf_i), .MF_PIN_O(mf_o),
    .MF_PIN_OE(mf_oe), .MF_FUNC_O(f_o), .MF_FUNC_OE(f_oe), .MF_FUNC_I(f_i)
  );
  pmx_board board (
    .sys_rst_n(rst_n), .mf_o(mf_o), .mf_oe(mf_oe), .mf_ext(mf_ext), .sync_o(sync_o), .sync_oe(sync_oe),
    .sync_ext(sync_ext), .mf_i(mf_i), .sync_i(sync_i), .trst_n(trst_n), .test_mode(test_mode), .crystal(xtal)
  );
  assign gp_i = ({xg_oe, gp_oe} & {xg_o, gp_o}) | (~{xg_oe, gp_oe} & gp_ext);

  initial begin
    forever #25 clk = ~clk;
  end
  // Whole run is a few hundred cycles; the margin covers a stuck bus
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) error_cnt++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] m;
    m = (a == `PMX_OFS_CTRL) ? 32'h3 : (a >= `PMX_OFS_GP_DIR) ? 32'h3FFFFF : 32'hFFFFFFF;
    apb(1'b1, a, d);
    mdl[a] = d & m;
  endtask
  task automatic reg_chk();
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, mdl[ofs[i]], "register read");
    end
  endtask
  task automatic do_reset(input logic [3:0] b);
    @(posedge clk);
    rst_n   <= 1'b0;
    boot_in <= b;
    repeat (11) @(posedge clk);
    #1;
    chk(hs, {4{topo}}, "high side in reset");
    chk(ls, 4'h0, "low side in reset");
    chk(mf_oe, PUMPS, "mf enables in reset");
    chk(mf_o, 28'h0, "mf levels in reset");
    chk({xg_oe, gp_oe}, 22'h0, "gp enables in reset");
    chk({sync_oe, osc_out}, {1'b0, xtal}, "sync and osc in reset");
    chk(boot_vld, 1'b0, "boot valid in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) mdl[ofs[i]] = 32'h0;
    mdl[`PMX_OFS_MF_DIR] = PUMPS;
    repeat (2) @(posedge clk);
    #1;
    chk({boot_vld, boot}, {1'b1, b}, "boot capture");
  endtask
  task automatic pad_chk();
    s   = mdl[`PMX_OFS_MF_SEL][27:0];
    eoe = (s & mdl[`PMX_OFS_MF_DIR][27:0]) | (~s & f_oe);
    eo  = (s & mdl[`PMX_OFS_MF_OUT][27:0]) | (~s & f_o);
    #1;
    chk(mf_oe, eoe, "mf enables");
    chk(mf_o, eo, "mf levels");
    chk(f_i, (eoe & eo) | (~eoe & mf_ext), "mf function inputs");
    chk({xg_oe, gp_oe}, mdl[`PMX_OFS_GP_DIR], "gp enables");
    chk({xg_o, gp_o}, mdl[`PMX_OFS_GP_OUT], "gp levels");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(4'hA);
    reg_chk();
    apb(1'b1, `PMX_OFS_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `PMX_OFS_STATUS, 32'h0);
    chk(rd, {23'h0, 4'hB, topo, 4'hA}, "status");
    for (int k = 0; k < 2; k++) begin
      apb(k[0], 8'h24, 32'hFFFFFFFF);
      chk({err, rd[30:0]}, 32'h80000000, "unmapped");
    end
    // Random selects, directions and peripheral drive on every pin
    repeat (4) begin
      for (int k = 1; k < 6; k++) wr(ofs[k], $random(seed));
      @(posedge clk);
      f_o    <= 28'($random(seed));
      f_oe   <= 28'($random(seed));
      mf_ext <= 28'($random(seed));
      gp_ext <= 22'($random(seed));
      repeat (4) @(posedge clk);
      pad_chk();
      apb(1'b0, `PMX_OFS_MF_IN, 32'h0);
      chk(rd, (eoe & eo) | (~eoe & mf_ext), "mf input read");
      apb(1'b0, `PMX_OFS_GP_IN, 32'h0);
      chk(rd, (mdl[`PMX_OFS_GP_DIR] & mdl[`PMX_OFS_GP_OUT]) | (~mdl[`PMX_OFS_GP_DIR] & {10'h0, gp_ext}),
          "gp input read");
      reg_chk();
    end
    // Both strap levels, with protection pins raising faults at random
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      topo   <= k[0];
      hi_req <= 4'($random(seed));
      lo_req <= 4'($random(seed));
      mf_ext <= 28'($random(seed));
      f_oe   <= 28'h0;
      repeat (4) @(posedge clk);
      #1;
      flt = (~s[23:20] & mf_ext[23:20]) | (~s[27:24] & mf_ext[27:24]);
      chk(hs, (hi_req & ~flt) ^ {4{topo}}, "high side");
      chk(ls, lo_req & ~flt, "low side");
    end
    wr(`PMX_OFS_CTRL, 32'h2);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      sync_tx <= ~k[0];
      repeat (3) @(posedge clk);
      #1;
      chk({sync_oe, sync_o}, {1'b1, ~k[0]}, "sync master");
    end
    wr(`PMX_OFS_CTRL, 32'h1);
    @(posedge clk);
    sync_ext <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({sync_oe, sync_rx, osc_out}, 3'h2, "sync slave, osc off");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {por, bo33, bo18} <= 3'(1 << k);
      #1;
      chk(rst_ind_n, 1'b0, "reset out asserted");
      @(posedge clk);
      {por, bo33, bo18} <= 3'h0;
      repeat (3) @(posedge clk);
      #1;
      chk(rst_ind_n, 1'b1, "reset out released");
    end
    // Second reset with every register away from its reset value
    do_reset(4'h5);
    reg_chk();
    print_verdict();
  end
endmodule
`default_nettype wire
